//--- bench/countdown_sva.sv
/*
  port assertions for the countdown timer.
  assumes a bind onto each timer instance; sees its ports only.
*/
`timescale 1ns/100ps
module countdown_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // watched ports
  input wire countdown_pkg::reg_req_t req,
  input wire logic [31:0] rdata_q,
  input wire logic expiry_irq,
  input wire logic [3:0] soft_irq_trigger_bit
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // decoded strobes
  wire logic sw_wr = req.wr && req.addr == 4'hc;
  wire logic ctl_wr = req.wr && req.addr == 4'h8;
  wire logic odd_rd = req.rd && !(req.addr inside {4'h0, 4'h4, 4'h8, 4'hc});
  property p_soft; sw_wr |=> soft_irq_trigger_bit == $past(req.wdata[3:0]); endproperty
  a_soft: assert property (p_soft)
    else $error("soft pulse wrong");
  property p_soft_q; !sw_wr |=> soft_irq_trigger_bit == 4'h0; endproperty
  a_soft_q: assert property (p_soft_q)
    else $error("soft pulse unasked");
  property p_swi_rd; req.rd && req.addr == 4'hc |=> rdata_q == 32'h0; endproperty
  a_swi_rd: assert property (p_swi_rd)
    else $error("soft reg read not zero");
  property p_odd_rd; odd_rd |=> rdata_q == 32'h0; endproperty
  a_odd_rd: assert property (p_odd_rd)
    else $error("unmapped read not zero");
  property p_rd_idle; !req.rd |=> rdata_q == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without read");
  property p_irq; expiry_irq |=> !expiry_irq; endproperty
  a_irq: assert property (p_irq)
    else $error("expiry pulse too long");
  // the edge taking the write may still show an earlier expiry
  property p_stop; ctl_wr && !req.wdata[2] |=> ##1 !expiry_irq [*2]; endproperty
  a_stop: assert property (p_stop)
    else $error("expiry after stop");
  property p_off; ctl_wr && !req.wdata[0] |-> ##2 !expiry_irq ##1 !expiry_irq; endproperty
  a_off: assert property (p_off)
    else $error("expiry after disable");
  c_irq: cover property (expiry_irq);
  c_soft: cover property (sw_wr);
  c_stop: cover property (ctl_wr && !req.wdata[2]);
endmodule : countdown_sva
bind low_power_countdown_timer countdown_sva u_sva (.core_clk(core_clk), .rstn(rstn),
  .req(req), .rdata_q(rdata_q), .expiry_irq(expiry_irq),
  .soft_irq_trigger_bit(soft_irq_trigger_bit));

//--- bench/tb_low_power_countdown_timer.sv
/*
  self-checking bench for the countdown timer.
  assumes the bound checker; drives ports 1 ns after each rising edge.
*/
`timescale 1ns/100ps
module tb_low_power_countdown_timer;
  logic core_clk = 0;
  logic rstn = 0;
  logic debug_halt = 0;
  countdown_pkg::reg_req_t req = '0;
  logic [31:0] rdata_q, got, v, r;
  logic [3:0] soft_irq_trigger_bit, sg;
  logic expiry_irq;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int tk, s;
  int seed = 32'he3a3;
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  low_power_countdown_timer DUT (.core_clk(core_clk), .rstn(rstn), .req(req),
    .rdata_q(rdata_q), .debug_halt(debug_halt), .expiry_irq(expiry_irq),
    .soft_irq_trigger_bit(soft_irq_trigger_bit));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // one access, then an idle cycle so strobes never repeat
  task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
    req = '{a, w, !w, d};
    @(posedge core_clk);
    #1 got = rdata_q;
    sg = soft_irq_trigger_bit;
    tk = cyc;
    req = '0;
    @(posedge core_clk);
    #1;
  endtask : acc
  // expiry must come n edges after edge b
  task automatic wait_irq(input int b, input int n);
    do begin
      @(posedge core_clk);
      #1;
    end while (expiry_irq !== 1'b1 && cyc - b < 300);
    chk("irq delay", n, cyc - b);
    tk = cyc;
  endtask : wait_irq
  // count drop over two edges
  task automatic gap(output logic [31:0] d);
    acc(4'h0, 0, 0);
    v = got;
    acc(4'h0, 0, 0);
    d = v - got;
  endtask : gap
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // watchdog, far beyond the 150 or so cycles needed
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rstn = 1;
    // defaults, soft register and an unmapped place read zero
    for (int i = 0; i < 5; i++) begin
      acc(i == 4 ? 4'h2 : 4'(i * 4), 0, 0);
      chk("reset read", 0, got);
    end
    $display("test reset done");
    acc(4'h8, 1, 32'h1);
    repeat (3) begin
      r = 4 + ($random(seed) & 7);
      acc(4'h4, 1, r);
      acc(4'h8, 1, 32'h5);
      // count is r after the start edge, irq registered on the edge reaching zero
      wait_irq(tk, r);
      acc(4'h8, 0, 0);
      chk("run cleared", 32'h1, got);
      acc(4'h0, 0, 0);
      chk("stays zero", 0, got);
    end
    $display("test one-shot done");
    v = 4 + ($random(seed) & 7);
    acc(4'h4, 1, r);
    acc(4'h8, 1, 32'h7);
    s = tk;
    acc(4'h4, 1, v);
    wait_irq(s, r);
    wait_irq(tk, v);
    $display("test repeat done");
    acc(4'h4, 1, 32'h100);
    acc(4'h8, 1, 32'h17);
    gap(v);
    chk("frozen", 0, v);
    debug_halt = 1;
    acc(4'h8, 1, 32'h0f);
    gap(v);
    chk("halt frozen", 0, v);
    acc(4'h8, 1, 32'h07);
    gap(v);
    chk("halt ignored", 2, v);
    debug_halt = 0;
    acc(4'h8, 1, 32'h3);
    acc(4'h0, 0, 0);
    chk("stopped", 0, got);
    $display("test hold done");
    acc(4'h4, 1, 0);
    acc(4'h8, 1, 32'h5);
    acc(4'h8, 0, 0);
    chk("zero start", 32'h1, got);
    v = $random(seed);
    acc(4'h0, 1, v);
    acc(4'h0, 0, 0);
    chk("count rw", v, got);
    acc(4'h4, 1, v);
    acc(4'h8, 1, 0);
    acc(4'h8, 1, 1);
    acc(4'h4, 0, 0);
    chk("disabled", 0, got);
    $display("test refuse done");
    repeat (4) begin
      v = $random(seed);
      acc(4'hc, 1, v);
      chk("soft", v[3:0], sg);
    end
    $display("test soft done");
    complete_run();
  end
endmodule : tb_low_power_countdown_timer

//--- core/countdown_core.sv
/*
  the 32-bit down counter with its reload and expiry detection.
  assumes load, clear and count commands come from the register block.
*/
`timescale 1ns/100ps
`include "countdown_regs.svh"
module countdown_core #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // commands
  input wire logic load_en,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic clear_en,
  input wire logic dec_en,
  // state
  output logic [WIDTH-1:0] count_q,
  output logic expire
);

  logic [WIDTH-1:0] count_d; // next count
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  // expiry is the 1-to-0 step itself; a clear never counts as one
  // load_en is left out on purpose: the parent builds load_en from expire,
  // so reading it here would close a combinational loop
  assign expire = dec_en && (count_q == ONE) && !clear_en; // see [RULE14]

  // clear beats load beats decrement
  assign count_d = clear_en ? '0 :
                   load_en ? load_val :
                   dec_en ? count_q - ONE : count_q; // see [RULE18]

  // count register, ticks from the always-on clock
  always_ff @(posedge core_clk or negedge rstn) begin // see [RULE15]
    if (!rstn) begin
      count_q <= `COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : countdown_core

//--- core/countdown_pkg.sv
/*
  types shared by the countdown timer files.
  assumes the register header is included where offsets are needed.
*/
package countdown_pkg;

  // control register fields, bit 0 lowest
  typedef struct packed {
    logic freeze;         // firmware freeze
    logic debug_follow;   // debug halt input obeyed
    logic run;            // run request
    logic repeat_on_exp;  // auto reload on expiry
    logic enable;         // block enable
  } control_t;

  // one register access, single-cycle strobes
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } reg_req_t;

  // run state of the counter
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FROZEN = 3'b100
  } run_state_t;

endpackage : countdown_pkg

//--- core/countdown_regs.svh
/*
  register offsets, control field positions, reset values and timing figures
  for the low-power countdown timer. assumes a 32-bit register port.
*/
`ifndef COUNTDOWN_REGS_SVH
`define COUNTDOWN_REGS_SVH

// byte offsets from the instance base
`define OFF_COUNTDOWN_VALUE 4'h0
`define OFF_RELOAD_SOURCE 4'h4
`define OFF_COUNTDOWN_CONTROL 4'h8
`define OFF_SOFTWARE_IRQ_TRIGGER 4'hc

// control field positions
`define CTL_ENABLE_BIT 0
`define CTL_REPEAT_BIT 1
`define CTL_RUN_BIT 2
`define CTL_DEBUG_FOLLOW_BIT 3
`define CTL_FREEZE_BIT 4
`define CTL_WIDTH 5

// reset values
`define COUNT_RESET 32'h0000_0000
`define RELOAD_RESET 32'h0000_0000
`define CONTROL_RESET 5'h00

// soft interrupt lines
`define SOFT_IRQ_LINES 4

// tick clock figure, in hertz; one decrement per edge
`define TICK_CLOCK_HZ 32768

`endif

//--- core/low_power_countdown_timer.sv
/*
  low-power countdown timer: four registers, run control, expiry and soft irqs.
  assumes core_clk is the always-on tick clock and system reset drives rstn;
  register strobes are synchronous single-cycle pulses.
*/
// Notes on behaviour
// [RULE1] live count readable and writable as a word
// [RULE2] reload on run request or repeating expiry
// [RULE3] software writes reload before run request
// [RULE4] new reload used only at next expiry
// [RULE5] freeze bit holds count, clear resumes
// [RULE6] debug halt freezes when follow bit set
// [RULE7] run request one loads and starts counting
// [RULE8] zero reload: no start, run bit clears
// [RULE9] run request zero stops, clears, no irq
// [RULE10] one-shot expiry clears run request bit
// [RULE11] repeat bit reloads and continues after expiry
// [RULE12] enable zero holds registers at defaults
// [RULE13] registers at offsets 00h 04h 08h 0Ch
// [RULE14] expiry irq on one to zero step
// [RULE15] all counting on always-on tick clock
// [RULE16] debug halt tied to processor halt
// [RULE17] soft irq bits pulse, reads zero
// [RULE18] decrement by one per tick edge
`timescale 1ns/100ps
`include "countdown_regs.svh"
module low_power_countdown_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire countdown_pkg::reg_req_t req,
  output logic [31:0] rdata_q,
  // debug halt from the processor halt source
  input wire logic debug_halt,
  // interrupts
  output logic expiry_irq,
  output logic [`SOFT_IRQ_LINES-1:0] soft_irq_trigger_bit
);

  // address decode, word aligned
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  wire sel_cnt = hit(req.addr, `OFF_COUNTDOWN_VALUE); // see [RULE13]
  wire sel_rld = hit(req.addr, `OFF_RELOAD_SOURCE);
  wire sel_ctl = hit(req.addr, `OFF_COUNTDOWN_CONTROL);
  wire sel_swi = hit(req.addr, `OFF_SOFTWARE_IRQ_TRIGGER);

  wire wr_cnt = req.wr && sel_cnt;
  wire wr_rld = req.wr && sel_rld;
  wire wr_ctl = req.wr && sel_ctl;
  wire wr_swi = req.wr && sel_swi;

  countdown_pkg::control_t ctl_q; // control register
  countdown_pkg::control_t ctl_d;
  countdown_pkg::control_t ctl_w; // written control value
  countdown_pkg::run_state_t state_q; // run state
  countdown_pkg::run_state_t state_d;
  logic [WIDTH-1:0] reload_q; // reload source
  logic [WIDTH-1:0] count_q; // live count
  logic expire; // 1-to-0 step this edge
  logic frozen; // either freeze source active
  logic start_req; // run request written one
  logic stop_req; // run request written zero
  logic load_en;
  logic clear_en;
  logic dec_en;
  logic [31:0] rdata_d;

  assign ctl_w = countdown_pkg::control_t'(req.wdata[`CTL_WIDTH-1:0]);

  // freeze from firmware or, when followed, the debug halt
  assign frozen = ctl_q.freeze || (ctl_q.debug_follow && debug_halt); // see [RULE5] [RULE6] [RULE16]

  // start/stop only with the block enabled
  assign start_req = wr_ctl && ctl_w.enable && ctl_w.run && (reload_q != '0); // see [RULE7]
  assign stop_req = wr_ctl && !ctl_w.run && ctl_q.run; // see [RULE9]

  // counting only while started, enabled and not frozen; the frozen state
  // counts as started so a cleared freeze resumes on the very next edge
  assign dec_en = (state_q != countdown_pkg::ST_IDLE) && ctl_q.enable && !frozen
                  && (count_q != '0); // see [RULE18]

  // reload on start, or on a repeating expiry with the current reload
  assign load_en = start_req || (expire && ctl_q.repeat_on_exp) ||
                   (wr_cnt && ctl_q.enable); // see [RULE2] [RULE4] [RULE11] [RULE1]

  // disable or stop clears the count
  assign clear_en = (wr_ctl && !ctl_w.enable) || !ctl_q.enable || stop_req; // see [RULE9] [RULE12]

  countdown_core #(
    .WIDTH(WIDTH)
  ) u_core (
    .core_clk(core_clk),
    .rstn(rstn),
    .load_en(load_en),
    .load_val(wr_cnt && !start_req && !(expire && ctl_q.repeat_on_exp)
              ? req.wdata[WIDTH-1:0] : reload_q),
    .clear_en(clear_en),
    .dec_en(dec_en),
    .count_q(count_q),
    .expire(expire)
  );

  // next control value
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = ctl_w;
      // zero reload refuses the start
      if (ctl_w.run && (reload_q == '0)) begin
        ctl_d.run = 1'b0; // see [RULE8]
      end
    end else if (expire && !ctl_q.repeat_on_exp) begin
      ctl_d.run = 1'b0; // see [RULE10]
    end
    // disabled block keeps every field at default
    if (!ctl_d.enable) begin
      ctl_d = countdown_pkg::control_t'(`CONTROL_RESET); // see [RULE12]
    end
  end

  // run state machine
  always_comb begin
    case (state_q)
      countdown_pkg::ST_IDLE: begin
        state_d = start_req ? countdown_pkg::ST_RUN : countdown_pkg::ST_IDLE;
      end
      countdown_pkg::ST_RUN, countdown_pkg::ST_FROZEN: begin
        if (clear_en || (expire && !ctl_q.repeat_on_exp)) begin
          state_d = countdown_pkg::ST_IDLE; // see [RULE11]
        end else if (frozen) begin
          state_d = countdown_pkg::ST_FROZEN;
        end else begin
          state_d = countdown_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = countdown_pkg::ST_IDLE;
      end
    endcase
  end

  // frozen state also counts as running for decrement purposes
  wire running = (state_q != countdown_pkg::ST_IDLE);

  // read mux; soft irq reads zero, unmapped reads zero
  assign rdata_d = sel_cnt ? 32'(count_q) : // see [RULE1]
                   sel_rld ? 32'(reload_q) :
                   sel_ctl ? {27'h0, ctl_q} : 32'h0; // see [RULE17]

  // control, reload, run state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= countdown_pkg::control_t'(`CONTROL_RESET);
      state_q <= countdown_pkg::ST_IDLE;
      reload_q <= `RELOAD_RESET;
    end else begin
      ctl_q <= ctl_d;
      // frozen state entered only from run; from idle it stays idle
      state_q <= (state_d == countdown_pkg::ST_FROZEN && !running) ?
                 countdown_pkg::ST_IDLE : state_d;
      // reload held at default while disabled
      if (!ctl_q.enable && !(wr_ctl && ctl_w.enable)) begin
        reload_q <= `RELOAD_RESET; // see [RULE12]
      end else if (wr_rld) begin
        reload_q <= req.wdata[WIDTH-1:0]; // see [RULE3] [RULE4]
      end
    end
  end

  // outputs registered: expiry and soft irq pulses, read data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      expiry_irq <= 1'b0;
      soft_irq_trigger_bit <= '0;
      rdata_q <= 32'h0;
    end else begin
      expiry_irq <= expire; // see [RULE14]
      soft_irq_trigger_bit <= wr_swi ? req.wdata[`SOFT_IRQ_LINES-1:0] : '0; // see [RULE17]
      rdata_q <= req.rd ? rdata_d : 32'h0;
    end
  end

endmodule : low_power_countdown_timer
